// [test/sp_far_dev.sv]
// Purpose: far serial device on the clock line and the shared data pin
// Assumes: bit_len is the mode 1 bit time in pclk cycles
// Notes:   after a mode 0 frame the data line holds its last value, which may be low
`timescale 1ns/1ps
module sp_far_dev (
   input  wire logic       pclk,
   input  wire logic       txd,
   input  wire logic       rxd_oe,
   input  wire logic       rxd_out,
   input  wire logic       async_mode,
   input  wire logic [7:0] bit_len,
   output logic            drv
);
   logic [7:0] m0_sr;
   logic [7:0] m0_byte;
   logic [7:0] cap;
   logic [7:0] u_byte;
   logic [8:0] sh;
   logic       u_stop;
   int         ncap  = 0;
   int         u_cnt = 0;
   initial drv = 1'b1;
   always @(negedge txd) if (!async_mode && !rxd_oe) begin
      drv   <= m0_sr[0];
      m0_sr <= {~m0_sr[0], m0_sr[7:1]};
   end
   always @(posedge txd) if (!async_mode && rxd_oe) begin
      cap = {rxd_out, cap[7:1]};
      ncap++;
      if (ncap % 8 == 0) m0_byte = cap;
   end
   task automatic send(input logic [9:0] frm, input int n);
      // idle the line first if a mode 0 frame left it low
      if (drv !== 1'b1) begin
         drv <= 1'b1;
         repeat (bit_len) @(posedge pclk);
      end
      for (int i = 0; i < n; i++) begin
         drv <= frm[i];
         repeat (bit_len) @(posedge pclk);
      end
      drv <= 1'b1;
   endtask : send
   always @(negedge txd) if (async_mode) begin
      repeat (bit_len / 2) @(posedge pclk);
      for (int i = 0; i < 9; i++) begin
         repeat (bit_len) @(posedge pclk);
         sh = {txd, sh[8:1]};
      end
      u_byte = sh[7:0];
      u_stop = sh[8];
      u_cnt++;
   end
endmodule : sp_far_dev

// [test/tb_top.sv]
// Purpose: self-checking bench of the two-mode serial port
// Assumes: 50 MHz pclk; reload 0xfffc gives 64-cycle bits in mode 1
// Notes:   far device model drives the data pin when the port does not
`timescale 1ns/1ps
module tb_top;
   logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, irq;
   logic        txd, rxd_in, rxd_out, rxd_oe, drv, am, e, txd_q, oe_q, irq_q;
   logic [7:0]  paddr, blen, b, c;
   logic [31:0] pwdata, prdata, r;
   int          seed, t0, dt, n_mismatch = 0, checked = 0, cyc = 0, t_fall = 0;
   int          t_oe = 0, t_irq = 0, per = 0, low = 0, lead = 0, nfall = 0;

   assign rxd_in = rxd_oe ? rxd_out : drv;
   sp_serial_port sp_serial_port_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq), .txd(txd), .rxd_in(rxd_in),
      .rxd_out(rxd_out), .rxd_oe(rxd_oe));
   sp_far_dev sp_far_dev_inst (.pclk(pclk), .txd(txd), .rxd_oe(rxd_oe), .rxd_out(rxd_out),
      .async_mode(am), .bit_len(blen), .drv(drv));

   initial pclk = 1'b0;
   always #10 pclk = ~pclk;

   // edge times of the shift clock, data enable and interrupt
   always @(posedge pclk) begin
      cyc   <= cyc + 1;
      txd_q <= txd;
      oe_q  <= rxd_oe;
      irq_q <= irq;
      if (rxd_oe && !oe_q) t_oe <= cyc;
      if (irq && !irq_q) t_irq <= cyc;
      if (txd && !txd_q) low <= cyc - t_fall;
      if (!txd && txd_q) begin
         per    <= cyc - t_fall;
         t_fall <= cyc;
         nfall  <= nfall + 1;
         if (t_oe > t_fall) lead <= cyc - t_oe;
      end
   end

   task automatic give_verdict;
      if (n_mismatch == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : give_verdict

   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      checked++;
      if (g !== x) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
      end
   endtask : chk

   // expected control read: writable nibble, ninth bit, done mirrors
   function automatic logic [31:0] ctrl_rd(input logic [7:0] w, input logic n, input logic t, input logic i);
      return {24'h000000, w[7:4], 1'b0, n, t, i};
   endfunction : ctrl_rd

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q   = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        x;
      apb(1'b1, a, d, q, x);
   endtask : wr

   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] x);
      logic y;
      apb(1'b0, a, 32'h0, r, y);
      chk(nm, x, r);
   endtask : rchk

   task automatic irqchk(input logic x);
      @(negedge pclk);
      chk("irq", x, irq);
   endtask : irqchk

   task automatic wait_stat(input logic [31:0] x);
      do apb(1'b0, sp_pkg::ADDR_STAT, 32'h0, r, e); while (r !== x);
   endtask : wait_stat

   initial begin
      seed    = 32'h1c5b;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      ce      = 1'b1;
      presetn = 1'b0;
      am      = 1'b0;
      blen    = 8'd64;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rchk("ctrl", sp_pkg::ADDR_CTRL, 32'h0);
      rchk("stat", sp_pkg::ADDR_STAT, 32'h0);
      rchk("mask", sp_pkg::ADDR_MASK, 32'h0);
      rchk("baud", sp_pkg::ADDR_BAUD, 32'h0ffff);
      apb(1'b0, 8'h14, 32'h0, r, e);
      chk("unmapped err", 1'b1, e);
      wr(sp_pkg::ADDR_CTRL, 32'hff);
      rchk("ctrl ro", sp_pkg::ADDR_CTRL, ctrl_rd(8'hff, 1'b0, 1'b0, 1'b0));
      wr(sp_pkg::ADDR_MASK, 32'h3);
      for (int q = 1; q >= 0; q--) begin
         b = $random(seed);
         wr(sp_pkg::ADDR_CTRL, q ? 32'h20 : 32'h0);
         wr(sp_pkg::ADDR_BUF, {24'h0, b});
         while (irq !== 1'b1) @(posedge pclk);
         chk("m0 byte", b, sp_far_dev_inst.m0_byte);
         chk("m0 period", q ? 4 : 12, per);
         chk("m0 low", q ? 2 : 6, low);
         chk("m0 lead", q ? 1 : 3, lead);
         rchk("m0 done", sp_pkg::ADDR_STAT, 32'h1);
         wr(sp_pkg::ADDR_MASK, 32'h0);
         irqchk(1'b0);
         wr(sp_pkg::ADDR_MASK, 32'h3);
         irqchk(1'b1);
         wr(sp_pkg::ADDR_STAT, 32'h1);
         irqchk(1'b0);
      end
      b = $random(seed);
      sp_far_dev_inst.m0_sr = b;
      wr(sp_pkg::ADDR_CTRL, 32'h10);
      wait_stat(32'h2);
      rchk("m0 rx", sp_pkg::ADDR_BUF, {24'h0, b});
      t0 = nfall;
      repeat (8) apb(1'b0, sp_pkg::ADDR_STAT, 32'h0, r, e);
      chk("m0 halt", t0, nfall);
      c = $random(seed);
      sp_far_dev_inst.m0_sr = c;
      wr(sp_pkg::ADDR_STAT, 32'h2);
      wait_stat(32'h2);
      rchk("m0 rx2", sp_pkg::ADDR_BUF, {24'h0, c});
      wr(sp_pkg::ADDR_CTRL, 32'h0);
      wr(sp_pkg::ADDR_STAT, 32'h2);
      am = 1'b1;
      wr(sp_pkg::ADDR_BAUD, 32'h0fffc);
      wr(sp_pkg::ADDR_CTRL, 32'h70);
      wr(sp_pkg::ADDR_MASK, 32'h1);
      for (int k = 0; k < 2; k++) begin
         b  = $random(seed);
         c  = $random(seed);
         t0 = cyc;
         fork
            wr(sp_pkg::ADDR_BUF, {24'h0, b});
            sp_far_dev_inst.send({1'b1, c, 1'b0}, 10);
         join
         wait_stat(32'h3);
         while (sp_far_dev_inst.u_cnt != k + 1) @(posedge pclk);
         chk("m1 tx", {1'b1, b}, {sp_far_dev_inst.u_stop, sp_far_dev_inst.u_byte});
         dt = t_irq - t0;
         chk("m1 done", 1'b1, dt >= 9 * blen && dt <= 10 * blen + 8);
         rchk("m1 rx", sp_pkg::ADDR_BUF, {24'h0, c});
         rchk("m1 ninth", sp_pkg::ADDR_CTRL, ctrl_rd(8'h70, 1'b1, 1'b1, 1'b1));
         wr(sp_pkg::ADDR_STAT, 32'h3);
         blen = 8'd128;
         wr(sp_pkg::ADDR_BAUD, 32'h1fffc);
      end
      blen = 8'd64;
      wr(sp_pkg::ADDR_BAUD, 32'h0fffc);
      sp_far_dev_inst.send({1'b1, c, 1'b0}, 10);
      fork
         sp_far_dev_inst.send({1'b1, ~c, 1'b0}, 10);
         wr(sp_pkg::ADDR_STAT, 32'h2);
      join
      rchk("back to back", sp_pkg::ADDR_BUF, {24'h0, ~c});
      sp_far_dev_inst.send({1'b1, c, 1'b0}, 10);
      rchk("rx kept", sp_pkg::ADDR_BUF, {24'h0, ~c});
      wr(sp_pkg::ADDR_STAT, 32'h2);
      sp_far_dev_inst.send({1'b0, c, 1'b0}, 10);
      rchk("bad stop q1", sp_pkg::ADDR_STAT, 32'h0);
      wr(sp_pkg::ADDR_CTRL, 32'h50);
      sp_far_dev_inst.send({1'b0, c, 1'b0}, 10);
      rchk("bad stop q0", sp_pkg::ADDR_CTRL, ctrl_rd(8'h50, 1'b0, 1'b0, 1'b1));
      rchk("bad stop buf", sp_pkg::ADDR_BUF, {24'h0, c});
      wr(sp_pkg::ADDR_STAT, 32'h2);
      blen = 8'd16;
      sp_far_dev_inst.send(10'h3fe, 8);
      blen = 8'd64;
      rchk("glitch", sp_pkg::ADDR_STAT, 32'h0);
      sp_far_dev_inst.send({1'b1, b, 1'b0}, 10);
      rchk("after glitch", sp_pkg::ADDR_BUF, {24'h0, b});
      give_verdict();
   end

   initial begin
      repeat (60000) @(posedge pclk);
      n_mismatch++;
      give_verdict();
   end
endmodule : tb_top

// [verilog/sp_baud.sv]
// Purpose: reload timer whose overflow gives the 16x bit-slice tick
// Assumes: ce freezes the count
// Notes:   tick is one pclk wide, except with an all-ones reload and div32 clear, when it stays high
`timescale 1ns/1ps
module sp_baud #(
   parameter int BAUD_W = 16
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              ce,
   input  wire logic [BAUD_W-1:0] reload,
   input  wire logic              div32,
   output logic                   tick
);
   if (BAUD_W < 2 || BAUD_W > 16) begin : g_bad_width
      $error("sp_baud: BAUD_W must be 2 to 16");
   end

   logic [BAUD_W-1:0] cnt_q;
   logic              half_q;
   wire               ovf = ce & (&cnt_q);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // start at the top so the first overflow reloads at once
         cnt_q  <= '1;
         half_q <= 1'b0;
      end else if (ce) begin
         cnt_q  <= ovf ? reload : cnt_q + 1'b1;
         half_q <= ovf ? ~half_q : half_q;
      end
   end

   // every overflow for 1/16, or every second overflow for 1/32
   assign tick = ovf & (~div32 | half_q);
endmodule : sp_baud

// [verilog/sp_pkg.sv]
// Purpose: shared constants of the two-mode serial port
// Assumes: byte addresses on a 32-bit apb bus
// Notes:   one word per register, unused bits read as zero
package sp_pkg;
   // register byte addresses
   localparam logic [7:0] ADDR_BUF  = 8'h00;
   localparam logic [7:0] ADDR_CTRL = 8'h04;
   localparam logic [7:0] ADDR_STAT = 8'h08;
   localparam logic [7:0] ADDR_MASK = 8'h0c;
   localparam logic [7:0] ADDR_BAUD = 8'h10;

   // serial_control fields
   localparam int CTRL_MODE_LSB = 6;
   localparam int CTRL_QUAL     = 5;
   localparam int CTRL_REN      = 4;
   localparam int CTRL_NINTH    = 2;
   localparam int CTRL_TI       = 1;
   localparam int CTRL_RI       = 0;
   localparam logic [3:0] CTRL_RST = 4'h0;

   // status and mask layout
   localparam int STAT_TX = 0;
   localparam int STAT_RX = 1;
   localparam int STAT_W  = 2;

   // baud register: reload in the low bits, divide-by-32 select above
   localparam int BAUD_DIV32 = 16;
   localparam logic [16:0] BAUD_RST = 17'h0ffff;

   // mode field encodings
   localparam logic [1:0] MODE_SYNC   = 2'h0;
   localparam logic [1:0] MODE_ASYNC  = 2'h1;

   // mode 0 phase counts in oscillator clocks, and bit positions
   localparam logic [3:0] M0_FAST_LAST = 4'h3;
   localparam logic [3:0] M0_FAST_FALL = 4'h1;
   localparam logic [3:0] M0_FAST_RISE = 4'h3;
   localparam logic [3:0] M0_SLOW_LAST = 4'hb;
   localparam logic [3:0] M0_SLOW_FALL = 4'h3;
   localparam logic [3:0] M0_SLOW_RISE = 4'h9;
   localparam logic [3:0] M0_LAST_BIT  = 4'h7;
   localparam logic [3:0] M0_RX_END    = 4'h8;

   // mode 1 divide-by-16 slices and frame positions
   localparam logic [3:0] DIV_LAST   = 4'hf;
   localparam logic [3:0] SMP_FIRST  = 4'h7;
   localparam logic [3:0] SMP_SECOND = 4'h8;
   localparam logic [3:0] SMP_THIRD  = 4'h9;
   localparam logic [3:0] FRAME_LAST = 4'h9;

   typedef enum logic [1:0] {
      M0_IDLE = 2'b00,
      M0_TX   = 2'b01,
      M0_RX   = 2'b10
   } sp_m0_type;

   typedef enum logic [0:0] {
      R1_IDLE = 1'b0,
      R1_RUN  = 1'b1
   } sp_r1_type;
endpackage : sp_pkg

// [verilog/sp_serial_port.sv]
// Purpose: serial port, synchronous mode 0 and 10-bit asynchronous mode 1, apb slave
// Assumes: pclk is the oscillator clock; rxd_in is an outside pin
// Notes:   modes 2 and 3 encodings leave the port inactive
//
// What this block does
// - one address: writes reach transmit register, reads return receive buffer.
// - mode 0 shifts 8 bits lsb first on data line, drives clock always.
// - mode 0 rate is 1/12 clock, or 1/4 with mode qualifier set.
// - fast mode 0: data 1 clock before clock falls, clock low 2.
// - slow mode 0: data 3 clocks before clock falls, clock low 6.
// - mode 0 sets transmit done right after the last bit ends.
// - mode 0 receives when enabled and receive done clear, 8 bits.
// - mode 0 sets receive done after last bit, then waits for clear.
// - mode 1 frame: start 0, 8 data lsb first, stop 1, full duplex.
// - mode 1 bit rate is 1/16 or 1/32 of timer overflow rate.
// - mode 1 transmit bits go out after divide-by-16 rollovers.
// - mode 1 transmit done set at tenth rollover with the stop bit.
// - mode 1 samples at 16x, falling edge resets divide-by-16 counter.
// - each received bit is 2-of-3 vote of slices 8, 9, 10.
// - a start bit voted 1 aborts reception back to edge watch.
// - load buffer, ninth bit and receive done only if allowed.
// - after stop bit middle, receiver watches for new falling edge.
//
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module sp_serial_port #(
   parameter int BAUD_W = 16
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             irq,
   output logic             txd,
   input  wire logic        rxd_in,
   output logic             rxd_out,
   output logic             rxd_oe
);
   if (BAUD_W < 2 || BAUD_W > 16) begin : g_bad_width
      $error("sp_serial_port: BAUD_W must be 2 to 16");
   end

   // register state
   logic [3:0]          ctrl_q;
   logic                ninth_q;
   logic [7:0]          rxbuf_q;
   logic [sp_pkg::STAT_W-1:0] stat_q;
   logic [sp_pkg::STAT_W-1:0] mask_q;
   logic [16:0]         baud_q;
   logic                rd_ok_q;
   logic [31:0]         prdata_q;

   // engines
   sp_pkg::sp_m0_type   m0_state_q;
   logic [3:0]          ph_q;
   logic [3:0]          bit_q;
   logic [7:0]          sh_q;
   logic                tx1_act_q;
   logic [3:0]          tx1_idx_q;
   logic [9:0]          tx1_fr_q;
   logic [3:0]          tx_div_q;
   sp_pkg::sp_r1_type   r1_state_q;
   logic [3:0]          r1_div_q;
   logic [3:0]          r1_idx_q;
   logic [1:0]          vote_q;
   logic [7:0]          r1_sh_q;
   logic                prev_q;
   logic [2:0]          rx_sync_q;
   logic                rx_s_q;
   logic                txd_q;
   logic                rxd_out_q;
   logic                rxd_oe_q;
   logic                tick;

   // field views
   wire [1:0] mode  = ctrl_q[sp_pkg::CTRL_MODE_LSB-4 +: 2];
   wire       qual  = ctrl_q[sp_pkg::CTRL_QUAL-4];
   wire       ren   = ctrl_q[sp_pkg::CTRL_REN-4];
   wire       mode0 = (mode == sp_pkg::MODE_SYNC);
   wire       mode1 = (mode == sp_pkg::MODE_ASYNC);
   wire       ri    = stat_q[sp_pkg::STAT_RX];

   // apb decode
   wire hit_buf  = (paddr == sp_pkg::ADDR_BUF);
   wire hit_ctrl = (paddr == sp_pkg::ADDR_CTRL);
   wire hit_stat = (paddr == sp_pkg::ADDR_STAT);
   wire hit_mask = (paddr == sp_pkg::ADDR_MASK);
   wire hit_baud = (paddr == sp_pkg::ADDR_BAUD);
   wire hit_any  = hit_buf | hit_ctrl | hit_stat | hit_mask | hit_baud;
   wire done_x   = psel & penable & pready;
   wire wr_en    = done_x & pwrite & hit_any;
   wire tx_start = wr_en & hit_buf;
   wire ld_rd    = ce & psel & ~rd_ok_q;

   wire [31:0] rdata_w =
      hit_buf  ? {24'h000000, rxbuf_q} :
      hit_ctrl ? {24'h000000, ctrl_q, 1'b0, ninth_q, stat_q[sp_pkg::STAT_TX], ri} :
      hit_stat ? {30'h00000000, stat_q} :
      hit_mask ? {30'h00000000, mask_q} :
      hit_baud ? {15'h0000, baud_q} :
      32'h00000000;

   assign pready  = ce & rd_ok_q;
   assign pslverr = psel & penable & ~hit_any;
   assign prdata  = prdata_q;
   assign irq     = |(stat_q & mask_q);
   assign txd     = txd_q;
   assign rxd_out = rxd_out_q;
   assign rxd_oe  = rxd_oe_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_ok_q  <= 1'b0;
         prdata_q <= 32'h00000000;
      end else if (ce) begin
         rd_ok_q  <= psel & ~(penable & rd_ok_q);
         prdata_q <= ld_rd ? rdata_w : prdata_q;
      end
   end

   // three-stage pin sampler; a change counts when stages two and three agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_sync_q <= 3'h7;
         rx_s_q    <= 1'b1;
      end else if (ce) begin
         rx_sync_q <= {rx_sync_q[1:0], rxd_in};
         if (rx_sync_q[1] == rx_sync_q[2]) begin
            rx_s_q <= rx_sync_q[2];
         end
      end
   end

   // bit-slice tick from the reload timer
   sp_baud #(
      .BAUD_W (BAUD_W)
   ) u_baud (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .reload  (baud_q[BAUD_W-1:0]),
      .div32   (baud_q[sp_pkg::BAUD_DIV32]),
      .tick    (tick)
   );

   // ---------------- mode 0 ----------------
   // phase lengths from the qualifier bit
   wire [3:0] m0_last = qual ? sp_pkg::M0_FAST_LAST : sp_pkg::M0_SLOW_LAST;
   wire [3:0] m0_fall = qual ? sp_pkg::M0_FAST_FALL : sp_pkg::M0_SLOW_FALL;
   wire [3:0] m0_rise = qual ? sp_pkg::M0_FAST_RISE : sp_pkg::M0_SLOW_RISE;
   wire       m0_end  = (ph_q == m0_last);
   wire       m0_idle = (m0_state_q == sp_pkg::M0_IDLE);
   wire       m0_tx   = (m0_state_q == sp_pkg::M0_TX);
   wire       m0_rx   = (m0_state_q == sp_pkg::M0_RX);
   // clock low window sits after the data change
   wire       sclk_lo = (m0_tx | (m0_rx & (bit_q != sp_pkg::M0_RX_END)))
                        & (ph_q >= m0_fall) & (ph_q < m0_rise);
   // receive only while enabled and receive done clear
   wire       m0_go_rx = mode0 & m0_idle & ren & ~ri & ~tx_start;
   // sampled bit seen through the pin sampler, one period late in slow mode, two in fast
   wire       m0_smp   = m0_rx & (ph_q == m0_fall) & (bit_q != 4'h0);
   wire [7:0] m0_sh_d  = m0_smp ? {rx_s_q, sh_q[7:1]} : sh_q;
   wire       m0_rdone = m0_smp & (bit_q == sp_pkg::M0_RX_END);
   wire       m0_tdone = m0_tx & m0_end & (bit_q == sp_pkg::M0_LAST_BIT);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         m0_state_q <= sp_pkg::M0_IDLE;
         ph_q       <= 4'h0;
         bit_q      <= 4'h0;
         sh_q       <= 8'h00;
      end else if (ce) begin
         case (m0_state_q)
            sp_pkg::M0_IDLE: begin
               ph_q  <= 4'h0;
               bit_q <= 4'h0;
               if (mode0 & tx_start) begin
                  m0_state_q <= sp_pkg::M0_TX;
                  sh_q       <= pwdata[7:0];
               end else if (m0_go_rx) begin
                  m0_state_q <= sp_pkg::M0_RX;
               end
            end
            sp_pkg::M0_TX: begin
               // lsb first, one bit per period
               ph_q <= m0_end ? 4'h0 : ph_q + 4'h1;
               if (m0_end) begin
                  bit_q <= bit_q + 4'h1;
                  sh_q  <= {1'b0, sh_q[7:1]};
               end
               if (m0_tdone) begin
                  m0_state_q <= sp_pkg::M0_IDLE;
               end
            end
            sp_pkg::M0_RX: begin
               ph_q <= m0_end ? 4'h0 : ph_q + 4'h1;
               sh_q <= m0_sh_d;
               if (m0_end) begin
                  bit_q <= bit_q + 4'h1;
               end
               if (m0_rdone) begin
                  m0_state_q <= sp_pkg::M0_IDLE;
               end
            end
            default: begin
               m0_state_q <= sp_pkg::M0_IDLE;
            end
         endcase
      end
   end

   // ---------------- mode 1 transmit ----------------
   wire roll    = tick & (tx_div_q == sp_pkg::DIV_LAST);
   wire tx1_go  = mode1 & tx_start & ~tx1_act_q;
   wire tx1_bit = tx1_act_q & roll;
   wire tx1_end = tx1_bit & (tx1_idx_q == sp_pkg::FRAME_LAST);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_div_q  <= 4'h0;
         tx1_act_q <= 1'b0;
         tx1_idx_q <= 4'h0;
         tx1_fr_q  <= 10'h3ff;
      end else if (ce) begin
         tx_div_q <= tick ? tx_div_q + 4'h1 : tx_div_q;
         // frame with start 0, data, stop 1
         if (tx1_go) begin
            tx1_act_q <= 1'b1;
            tx1_idx_q <= 4'h0;
            tx1_fr_q  <= {1'b1, pwdata[7:0], 1'b0};
         end else if (tx1_bit) begin
            tx1_fr_q  <= {1'b1, tx1_fr_q[9:1]};
            tx1_idx_q <= tx1_idx_q + 4'h1;
            tx1_act_q <= ~tx1_end;
         end
      end
   end

   // pin drivers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         txd_q     <= 1'b1;
         rxd_out_q <= 1'b1;
         rxd_oe_q  <= 1'b0;
      end else if (ce) begin
         if (mode0) begin
            txd_q <= ~sclk_lo;
         end else if (mode1) begin
            txd_q <= tx1_bit ? tx1_fr_q[0] : txd_q;
         end else begin
            txd_q <= 1'b1;
         end
         rxd_out_q <= m0_tx ? sh_q[0] : 1'b1;
         rxd_oe_q  <= mode0 & m0_tx;
      end
   end

   // ---------------- mode 1 receive ----------------
   // majority of slices 8, 9, 10
   wire maj     = (vote_q[0] & vote_q[1]) | (vote_q[0] & rx_s_q) | (vote_q[1] & rx_s_q);
   wire r1_run  = (r1_state_q == sp_pkg::R1_RUN);
   wire r1_dec  = r1_run & tick & (r1_div_q == sp_pkg::SMP_THIRD);
   // falling edge seen at the 16x rate
   wire r1_edge = ~r1_run & mode1 & ren & tick & prev_q & ~rx_s_q;
   wire r1_stop = r1_dec & (r1_idx_q == sp_pkg::FRAME_LAST);
   // load only with receive done clear and an allowed stop bit
   wire r1_load = r1_stop & ~ri & (~qual | maj);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r1_state_q <= sp_pkg::R1_IDLE;
         r1_div_q   <= 4'h0;
         r1_idx_q   <= 4'h0;
         vote_q     <= 2'h3;
         r1_sh_q    <= 8'h00;
         prev_q     <= 1'b1;
      end else if (ce) begin
         prev_q <= tick ? rx_s_q : prev_q;
         if (r1_edge) begin
            r1_state_q <= sp_pkg::R1_RUN;
            r1_div_q   <= 4'h0;
            r1_idx_q   <= 4'h0;
         end else if (r1_run & tick) begin
            r1_div_q <= r1_div_q + 4'h1;
            if (r1_div_q == sp_pkg::SMP_FIRST) begin
               vote_q[0] <= rx_s_q;
            end
            if (r1_div_q == sp_pkg::SMP_SECOND) begin
               vote_q[1] <= rx_s_q;
            end
            if (r1_dec) begin
               r1_idx_q <= r1_idx_q + 4'h1;
               if (r1_idx_q != 4'h0 && !r1_stop) begin
                  r1_sh_q <= {maj, r1_sh_q[7:1]};
               end
               // back to edge watch at stop middle
               if ((r1_idx_q == 4'h0 && maj) || r1_stop || !mode1) begin
                  r1_state_q <= sp_pkg::R1_IDLE;
               end
            end
         end
      end
   end

   // ---------------- registers ----------------
   // transmit done; at the tenth rollover in mode 1, at the end of the last bit in mode 0
   wire [sp_pkg::STAT_W-1:0] set_w = {m0_rdone | r1_load, m0_tdone | tx1_end};
   wire [sp_pkg::STAT_W-1:0] clr_w = (wr_en & hit_stat) ? pwdata[sp_pkg::STAT_W-1:0] : '0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q  <= sp_pkg::CTRL_RST;
         baud_q  <= sp_pkg::BAUD_RST;
         mask_q  <= '0;
         stat_q  <= '0;
         rxbuf_q <= 8'h00;
         ninth_q <= 1'b0;
      end else if (ce) begin
         if (wr_en & hit_ctrl) begin
            ctrl_q <= pwdata[7:4];
         end
         if (wr_en & hit_baud) begin
            baud_q <= pwdata[16:0];
         end
         if (wr_en & hit_mask) begin
            mask_q <= pwdata[sp_pkg::STAT_W-1:0];
         end
         // a new event wins over a clear in the same cycle
         stat_q <= (stat_q & ~clr_w) | set_w;
         if (m0_rdone) begin
            rxbuf_q <= m0_sh_d;
         end else if (r1_load) begin
            rxbuf_q <= r1_sh_q;
            ninth_q <= maj;
         end
      end
   end

   // ---------------- checks ----------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_buf_read;
      ld_rd && !pwrite && hit_buf |=> prdata[7:0] == $past(rxbuf_q);
   endproperty
   a_buf_read: assert property (p_buf_read) else $error("buffer read wrong");

   property p_m0_fall;
      ce && m0_tx && mode0 && ph_q == m0_fall |=> $fell(txd);
   endproperty
   a_m0_fall: assert property (p_m0_fall) else $error("shift clock fall misplaced");

   property p_m0_low_fast;
      $fell(txd) && mode0 && qual |-> !txd [*2];
   endproperty
   a_m0_low_fast: assert property (p_m0_low_fast) else $error("fast clock low too short");

   property p_m0_low_slow;
      $fell(txd) && mode0 && !qual |-> !txd [*6];
   endproperty
   a_m0_low_slow: assert property (p_m0_low_slow) else $error("slow clock low too short");

   property p_m0_ti;
      ce && m0_tdone |=> stat_q[sp_pkg::STAT_TX] && m0_idle;
   endproperty
   a_m0_ti: assert property (p_m0_ti) else $error("mode 0 transmit done missing");

   property p_m0_ri_block;
      m0_idle && ri && !tx_start |=> !m0_rx;
   endproperty
   a_m0_ri_block: assert property (p_m0_ri_block) else $error("receive started with done set");

   property p_m1_start;
      ce && tx1_bit && tx1_idx_q == 4'h0 && mode1 |=> !txd;
   endproperty
   a_m1_start: assert property (p_m1_start) else $error("start bit not low");

   property p_m1_ti;
      ce && tx1_end |=> stat_q[sp_pkg::STAT_TX] && !tx1_act_q && txd;
   endproperty
   a_m1_ti: assert property (p_m1_ti) else $error("mode 1 transmit done wrong");

   property p_m1_resync;
      ce && r1_edge |=> r1_run && r1_div_q == 4'h0;
   endproperty
   a_m1_resync: assert property (p_m1_resync) else $error("edge did not reset divider");

   property p_m1_abort;
      ce && r1_dec && r1_idx_q == 4'h0 && maj |=> !r1_run;
   endproperty
   a_m1_abort: assert property (p_m1_abort) else $error("bad start bit not aborted");

   property p_m1_drop;
      ce && r1_stop && (ri || (qual && !maj)) |=> $stable(rxbuf_q);
   endproperty
   a_m1_drop: assert property (p_m1_drop) else $error("frame loaded when not allowed");
endmodule : sp_serial_port
